// ### verilog/pwm_consts.svh
// register offsets, field positions and reset values of the pwm block
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

`define OFS_PRESCALE  8'h00
`define OFS_CLKSEL    8'h04
`define OFS_CTRL      8'h08
`define OFS_DEADTIME  8'h0c
`define OFS_PERIOD0   8'h10
`define OFS_COUNT0    8'h50
`define OFS_IRQ_EN    8'h70
`define OFS_IRQ_IND   8'h74
`define OFS_CAPCTL0   8'h78
`define OFS_LATCH0    8'h88
`define OFS_END       8'hc8

`define CTRL_EN       0
`define CTRL_AUTO     1
`define CTRL_CENTER   2
`define CTRL_DZ       24

`define CAP_EN        0
`define CAP_RISE_IE   1
`define CAP_FALL_IE   2
`define CAP_CH_STEP   16

`define DIV_MAX       3'h4
`define RST_WORD      32'h0000_0000
`define RST_HALF      16'h0000
`define RST_BYTE      8'h00

`endif

// ### verilog/pwm_pkg.sv
// shared types of the pwm block
`default_nettype none
package pwm_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_DOWN, ST_UP, ST_DONE} cnt_state_t;
endpackage : pwm_pkg
`default_nettype wire

// ### verilog/pwm_channel.sv
// one pwm timer channel: divider, double-buffered period counter and comparator
`timescale 1ns/1ps
`default_nettype none
`include "pwm_consts.svh"
module pwm_channel (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        presc_tick,
   input  wire logic [2:0]  div_sel,
   input  wire logic        enable,
   input  wire logic        auto_reload,
   input  wire logic        center,
   input  wire logic [15:0] period_buf,
   input  wire logic [15:0] cmp_buf,
   input  wire logic        reload_req,
   output logic      [15:0] count,
   output logic             out,
   output logic             zero
);
   pwm_pkg::cnt_state_t st_reg, st_next;
   logic [3:0]  div_reg, div_next, mask;
   logic [15:0] cnt_reg, cnt_next, cmp_reg, cmp_next, per_reg, per_next;
   logic        out_reg, out_next, zero_reg, zero_next, tick;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mask = (div_sel > `DIV_MAX) ? 4'hf : 4'((5'h1 << div_sel) - 5'h1);
      tick = presc_tick & ((div_reg & mask) == mask);
      div_next = presc_tick ? div_reg + 4'h1 : div_reg;
      st_next = st_reg;
      cnt_next = cnt_reg;
      cmp_next = cmp_reg;
      per_next = per_reg;
      zero_next = 1'b0;
      if (!enable) begin
         st_next = pwm_pkg::ST_IDLE;
      end else if (reload_req && (st_reg == pwm_pkg::ST_DOWN || st_reg == pwm_pkg::ST_UP)) begin
         cnt_next = period_buf;
         st_next = pwm_pkg::ST_DOWN;
      end else begin
         unique case (st_reg)
            pwm_pkg::ST_IDLE: begin
               cnt_next = period_buf;
               per_next = period_buf;
               cmp_next = cmp_buf;
               st_next = pwm_pkg::ST_DOWN;
            end
            pwm_pkg::ST_DOWN: begin
               if (tick && cnt_reg == `RST_HALF) begin
                  zero_next = 1'b1;
                  cmp_next = cmp_buf;
                  per_next = period_buf;
                  if (!auto_reload)
                     st_next = pwm_pkg::ST_DONE;
                  else if (center)
                     st_next = pwm_pkg::ST_UP;
                  else
                     cnt_next = period_buf;
               end else if (tick) begin
                  cnt_next = cnt_reg - 16'h1;
               end
            end
            pwm_pkg::ST_UP: begin
               // peak and valley each last two ticks, keeping the wave symmetric
               if (tick && cnt_reg >= per_reg)
                  st_next = pwm_pkg::ST_DOWN;
               else if (tick)
                  cnt_next = cnt_reg + 16'h1;
            end
            pwm_pkg::ST_DONE: st_next = st_reg;
         endcase
      end
      out_next = (st_next == pwm_pkg::ST_DOWN || st_next == pwm_pkg::ST_UP)
                 && cnt_next <= cmp_next;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg   <= pwm_pkg::ST_IDLE;
         div_reg  <= 4'h0;
         cnt_reg  <= `RST_HALF;
         cmp_reg  <= `RST_HALF;
         per_reg  <= `RST_HALF;
         out_reg  <= 1'b0;
         zero_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         div_reg  <= div_next;
         cnt_reg  <= cnt_next;
         cmp_reg  <= cmp_next;
         per_reg  <= per_next;
         out_reg  <= out_next;
         zero_reg <= zero_next;
      end
   end

   assign count = cnt_reg;
   assign out   = out_reg;
   assign zero  = zero_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_AUTO_RELOAD: assert property (enable && st_reg == pwm_pkg::ST_DOWN && !reload_req
      && tick && cnt_reg == 16'h0 && auto_reload && !center |=> cnt_reg == $past(period_buf))
      else $error("counter not reloaded at zero");
   AST_ONE_SHOT: assert property (enable && st_reg == pwm_pkg::ST_DOWN && !reload_req
      && tick && cnt_reg == 16'h0 && !auto_reload |=> st_reg == pwm_pkg::ST_DONE && zero_reg)
      else $error("one-shot counter did not stop");
   AST_DOWN_STEP: assert property (enable && st_reg == pwm_pkg::ST_DOWN && !reload_req
      && tick && cnt_reg != 16'h0 |=> cnt_reg == $past(cnt_reg) - 16'h1)
      else $error("counter did not step down");
   AST_DBL_BUF: assert property (enable && st_reg != pwm_pkg::ST_IDLE
      && !(st_reg == pwm_pkg::ST_DOWN && tick && cnt_reg == 16'h0) |=> $stable(cmp_reg))
      else $error("comparator changed away from zero");
   AST_OUT_MATCH: assert property (out_reg |-> cnt_reg <= cmp_reg && st_reg != pwm_pkg::ST_DONE)
      else $error("output high above compare value");
   AST_CAP_RELOAD: assert property (enable && reload_req
      && (st_reg == pwm_pkg::ST_DOWN || st_reg == pwm_pkg::ST_UP) |=> cnt_reg == $past(period_buf))
      else $error("capture did not reload counter");
   COV_ONE_SHOT: cover property (zero_reg && st_reg == pwm_pkg::ST_DONE);
   COV_CENTER: cover property (st_reg == pwm_pkg::ST_UP ##1 st_reg == pwm_pkg::ST_DOWN);
endmodule : pwm_channel
`default_nettype wire

// ### verilog/pwm_deadzone.sv
// dead-zone generator: turns one pwm wave into a complementary pair
`timescale 1ns/1ps
`default_nettype none
`include "pwm_consts.svh"
module pwm_deadzone (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       tick,
   input  wire logic       src,
   input  wire logic [7:0] dead_time,
   output logic            out_a,
   output logic            out_b
);
   logic [7:0] dcnt_reg, dcnt_next;
   logic       prev_reg, a_reg, a_next, b_reg, b_next, settled;

   always_comb begin
      dcnt_next = dcnt_reg;
      if (src != prev_reg)
         dcnt_next = `RST_BYTE;
      else if (tick && dcnt_reg < dead_time)
         dcnt_next = dcnt_reg + 8'h1;
      // both low in the edge cycle, so the pair can never overlap
      settled = (src == prev_reg) && (dcnt_next >= dead_time);
      a_next = src & settled;
      b_next = ~src & settled;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dcnt_reg <= `RST_BYTE;
         prev_reg <= 1'b0;
         a_reg    <= 1'b0;
         b_reg    <= 1'b0;
      end else begin
         dcnt_reg <= dcnt_next;
         prev_reg <= src;
         a_reg    <= a_next;
         b_reg    <= b_next;
      end
   end

   assign out_a = a_reg;
   assign out_b = b_reg;
endmodule : pwm_deadzone
`default_nettype wire

// ### verilog/pwm_capture_top.sv
// pwm generator with capture, ahb-lite register slave on top
`timescale 1ns/1ps
`default_nettype none
`include "pwm_consts.svh"
module pwm_capture_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [7:0]  cap_in,
   output logic      [7:0]  pwm_out,
   output logic      [7:0]  pwm_oe,
   output logic             pwm_irq
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [31:0] presc_reg, presc_next, clksel_reg, clksel_next;
   logic [31:0] ctrl_reg, ctrl_next, dtime_reg, dtime_next;
   logic [15:0] per_reg [8];
   logic [15:0] per_next [8];
   logic [15:0] cmp_reg [8];
   logic [15:0] cmp_next [8];
   logic [31:0] ccr_reg [4];
   logic [31:0] ccr_next [4];
   logic [15:0] rlat_reg [8];
   logic [15:0] rlat_next [8];
   logic [15:0] flat_reg [8];
   logic [15:0] flat_next [8];
   logic [7:0]  pcnt_reg [4];
   logic [7:0]  pcnt_next [4];
   logic [7:0]  irq_en_reg, irq_en_next, pflag_reg, pflag_next;
   logic [7:0]  cflag_reg, cflag_next, prev_reg, pclr, cclr;
   logic        irq_reg, irq_next, wr_reg, wr_next;
   logic [7:0]  wa_reg, wa_next;
   logic [31:0] rd_reg, rd_next;

   // channel and capture wiring
   logic [15:0] ch_cnt [8];
   logic [7:0]  ch_out, ch_zero, cap_en, rise, fall, cap_ev;
   logic [3:0]  ptick, dz_a, dz_b, dz_on;
   logic [7:0]  ra, rpo, rco, rko, rlo, wpo, wko;
   logic        acc;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite: zero wait states, read data captured in the address phase
   assign acc = hsel & htrans[1] & hready;

   always_comb begin
      ra  = haddr[7:0];
      rpo = ra - `OFS_PERIOD0;
      rco = ra - `OFS_COUNT0;
      rko = ra - `OFS_CAPCTL0;
      rlo = ra - `OFS_LATCH0;
      wr_next = acc & hwrite;
      wa_next = acc ? haddr[7:0] : wa_reg;
      rd_next = rd_reg;
      if (acc && !hwrite) begin
         rd_next = `RST_WORD;
         if (ra == `OFS_PRESCALE)
            rd_next = presc_reg;
         else if (ra == `OFS_CLKSEL)
            rd_next = clksel_reg;
         else if (ra == `OFS_CTRL)
            rd_next = ctrl_reg;
         else if (ra == `OFS_DEADTIME)
            rd_next = dtime_reg;
         else if (ra >= `OFS_PERIOD0 && ra < `OFS_COUNT0)
            rd_next = {16'h0, rpo[2] ? cmp_reg[rpo[5:3]] : per_reg[rpo[5:3]]};
         else if (ra >= `OFS_COUNT0 && ra < `OFS_IRQ_EN)
            rd_next = {16'h0, ch_cnt[rco[4:2]]};
         else if (ra == `OFS_IRQ_EN)
            rd_next = {24'h0, irq_en_reg};
         else if (ra == `OFS_IRQ_IND)
            rd_next = {16'h0, cflag_reg, pflag_reg};
         else if (ra >= `OFS_CAPCTL0 && ra < `OFS_LATCH0)
            rd_next = ccr_reg[rko[3:2]];
         else if (ra >= `OFS_LATCH0 && ra < `OFS_END)
            rd_next = {16'h0, rlo[2] ? flat_reg[rlo[5:3]] : rlat_reg[rlo[5:3]]};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_reg <= 1'b0;
         wa_reg <= `RST_BYTE;
         rd_reg <= `RST_WORD;
      end else begin
         wr_reg <= wr_next;
         wa_reg <= wa_next;
         rd_reg <= rd_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // software registers, flags, latches and prescalers
   always_comb begin
      wpo = wa_reg - `OFS_PERIOD0;
      wko = wa_reg - `OFS_CAPCTL0;
      presc_next  = presc_reg;
      clksel_next = clksel_reg;
      ctrl_next   = ctrl_reg;
      dtime_next  = dtime_reg;
      irq_en_next = irq_en_reg;
      per_next    = per_reg;
      cmp_next    = cmp_reg;
      ccr_next    = ccr_reg;
      rlat_next   = rlat_reg;
      flat_next   = flat_reg;
      pclr = `RST_BYTE;
      cclr = `RST_BYTE;
      if (wr_reg) begin
         if (wa_reg == `OFS_PRESCALE)
            presc_next = hwdata;
         if (wa_reg == `OFS_CLKSEL)
            clksel_next = hwdata;
         if (wa_reg == `OFS_CTRL)
            ctrl_next = hwdata;
         if (wa_reg == `OFS_DEADTIME)
            dtime_next = hwdata;
         if (wa_reg == `OFS_IRQ_EN)
            irq_en_next = hwdata[7:0];
         if (wa_reg == `OFS_IRQ_IND) begin
            pclr = hwdata[7:0];
            cclr = hwdata[15:8];
         end
         if (wa_reg >= `OFS_PERIOD0 && wa_reg < `OFS_COUNT0) begin
            if (wpo[2])
               cmp_next[wpo[5:3]] = hwdata[15:0];
            else
               per_next[wpo[5:3]] = hwdata[15:0];
         end
         if (wa_reg >= `OFS_CAPCTL0 && wa_reg < `OFS_LATCH0)
            ccr_next[wko[3:2]] = hwdata;
      end
      // a hardware set in the clearing cycle wins
      pflag_next = (pflag_reg & ~pclr) | ch_zero;
      cflag_next = (cflag_reg & ~cclr) | cap_ev;
      irq_next = (|(pflag_reg & irq_en_reg)) | (|cflag_reg);
      for (int i = 0; i < 8; i++) begin
         if (rise[i])
            rlat_next[i] = ch_cnt[i];
         if (fall[i])
            flat_next[i] = ch_cnt[i];
      end
      for (int g = 0; g < 4; g++) begin
         ptick[g] = (pcnt_reg[g] >= presc_reg[8*g +: 8]);
         pcnt_next[g] = ptick[g] ? `RST_BYTE : pcnt_reg[g] + 8'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_reg  <= `RST_WORD;
         clksel_reg <= `RST_WORD;
         ctrl_reg   <= `RST_WORD;
         dtime_reg  <= `RST_WORD;
         irq_en_reg <= `RST_BYTE;
         pflag_reg  <= `RST_BYTE;
         cflag_reg  <= `RST_BYTE;
         prev_reg   <= `RST_BYTE;
         irq_reg    <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            per_reg[i]  <= `RST_HALF;
            cmp_reg[i]  <= `RST_HALF;
            rlat_reg[i] <= `RST_HALF;
            flat_reg[i] <= `RST_HALF;
         end
         for (int g = 0; g < 4; g++) begin
            ccr_reg[g]  <= `RST_WORD;
            pcnt_reg[g] <= `RST_BYTE;
         end
      end else begin
         presc_reg  <= presc_next;
         clksel_reg <= clksel_next;
         ctrl_reg   <= ctrl_next;
         dtime_reg  <= dtime_next;
         irq_en_reg <= irq_en_next;
         pflag_reg  <= pflag_next;
         cflag_reg  <= cflag_next;
         prev_reg   <= cap_in;
         irq_reg    <= irq_next;
         per_reg    <= per_next;
         cmp_reg    <= cmp_next;
         rlat_reg   <= rlat_next;
         flat_reg   <= flat_next;
         ccr_reg    <= ccr_next;
         pcnt_reg   <= pcnt_next;
      end
   end

   assign pwm_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // eight channels; generator g owns channels 2g and 2g+1
   for (genvar c = 0; c < 8; c++) begin : g_ch
      localparam int K = c / 2;
      localparam int B = (c % 2) * `CAP_CH_STEP;
      assign cap_en[c] = ccr_reg[K][B + `CAP_EN];
      assign rise[c] = cap_en[c] & cap_in[c] & ~prev_reg[c];
      assign fall[c] = cap_en[c] & ~cap_in[c] & prev_reg[c];
      assign cap_ev[c] = (rise[c] & ccr_reg[K][B + `CAP_RISE_IE])
                       | (fall[c] & ccr_reg[K][B + `CAP_FALL_IE]);
      assign pwm_oe[c] = ~cap_en[c];

      pwm_channel u_ch (
         .clk         (hclk),
         .rst_n       (hresetn),
         .presc_tick  (ptick[K]),
         .div_sel     (clksel_reg[4*c +: 3]),
         .enable      (ctrl_reg[3*c + `CTRL_EN]),
         .auto_reload (ctrl_reg[3*c + `CTRL_AUTO]),
         .center      (ctrl_reg[3*c + `CTRL_CENTER]),
         .period_buf  (per_reg[c]),
         .cmp_buf     (cmp_reg[c]),
         .reload_req  (cap_ev[c]),
         .count       (ch_cnt[c]),
         .out         (ch_out[c]),
         .zero        (ch_zero[c])
      );
   end

   // pair p runs from the even timer and dead-zone generator of its generator
   for (genvar p = 0; p < 4; p++) begin : g_pair
      assign dz_on[p] = ctrl_reg[`CTRL_DZ + p];

      pwm_deadzone u_dz (
         .clk       (hclk),
         .rst_n     (hresetn),
         .tick      (ptick[p]),
         .src       (ch_out[2*p]),
         .dead_time (dtime_reg[8*p +: 8]),
         .out_a     (dz_a[p]),
         .out_b     (dz_b[p])
      );

      assign pwm_out[2*p]   = dz_on[p] ? dz_a[p] : ch_out[2*p];
      assign pwm_out[2*p+1] = dz_on[p] ? dz_b[p] : ch_out[2*p+1];
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_PERIOD_FLAG: assert property (ch_zero[0] |=> pflag_reg[0] ##1 pwm_irq || !irq_en_reg[0])
      else $error("period flag or interrupt missing");
   AST_IRQ_GATE: assert property ((pflag_reg & irq_en_reg) == 8'h0 && cflag_reg == 8'h0
      |=> !pwm_irq)
      else $error("interrupt raised without enabled flag");
   AST_RISE_LATCH: assert property (cap_en[0] && cap_in[0] && !prev_reg[0]
      |=> rlat_reg[0] == $past(ch_cnt[0]))
      else $error("rising latch not loaded");
   AST_FALL_LATCH: assert property (cap_en[0] && !cap_in[0] && prev_reg[0]
      |=> flat_reg[0] == $past(ch_cnt[0]))
      else $error("falling latch not loaded");
   AST_CAP_PIN: assert property (cap_en[0] |-> !pwm_oe[0])
      else $error("capture pin still driven");
   AST_CAP_FLAG: assert property (rise[0] && ccr_reg[0][`CAP_RISE_IE] |=> cflag_reg[0])
      else $error("capture flag not set");
   AST_PAIR_SPLIT: assert property (dz_on[0] |-> !(pwm_out[0] && pwm_out[1]))
      else $error("complementary pair overlaps");
   COV_IRQ: cover property (pwm_irq);
   COV_CAPTURE: cover property (cflag_reg[0] ##1 !cflag_reg[0]);
   COV_PAIR: cover property (dz_on[0] && pwm_out[0] ##[1:50] dz_on[0] && pwm_out[1]);
endmodule : pwm_capture_top
`default_nettype wire

// ### test/board_loads.sv
// board-side model: capture sources on the shared pins and pair overlap watch
`timescale 1ns/1ps
`default_nettype none
module board_loads (
   input  wire logic       hclk,
   input  wire logic [7:0] src,
   input  wire logic [7:0] pwm_out,
   input  wire logic [7:0] pwm_oe,
   output logic      [7:0] cap_in,
   output logic            overlap
);
   // a pin shows the device drive while enabled, else the board source
   assign cap_in = (pwm_oe & pwm_out) | (~pwm_oe & src);
   initial overlap = 1'b0;
   always @(posedge hclk) begin
      if (pwm_oe[0] && pwm_oe[1] && pwm_out[0] && pwm_out[1]) begin
         overlap <= 1'b1;
      end
   end
endmodule : board_loads
`default_nettype wire

// ### test/testbench.sv
// self-checking bench of the pwm block with capture over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "pwm_consts.svh"
module testbench;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pwm_irq, overlap;
   logic [1:0]  htrans, pv;
   logic [31:0] haddr, hwdata, hrdata, q, seed;
   logic [7:0]  cap_in, pwm_out, pwm_oe, src;
   int          num_errors, num_checks, cyc, t, tk, hi0, hi1;

   pwm_capture_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cap_in(cap_in),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_irq(pwm_irq));
   board_loads bl (.hclk(hclk), .src(src), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .cap_in(cap_in), .overlap(overlap));

   initial hclk = 1'b0;
   always #25 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run

   function logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // idle after a write: the register only updates at the data-phase edge, so a read right behind it would still return the old value
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      if (w) @(posedge hclk);
   endtask : bus

   task watch(input int n);
      hi0 = 0;
      hi1 = 0;
      repeat (n) begin
         @(posedge hclk);
         hi0 += int'(pwm_out[0]);
         hi1 += int'(pwm_out[1]);
      end
   endtask : watch

   task wait_irq(input int lim);
      t = 0;
      hi0 = 0;
      while (pwm_irq !== 1'b1 && t < lim) begin
         @(posedge hclk);
         t++;
         hi0 += int'(pwm_out[0]);
      end
   endtask : wait_irq
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      src = 8'h00;
      seed = 32'h0cd5;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({14'h0, pwm_irq, hresp, pwm_oe, pwm_out}, 32'h0000ff00);
      bus(1'b0, `OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, `OFS_END, 32'h0);
      chk(q, 32'h0);
      seed = xs(seed);
      bus(1'b1, `OFS_PERIOD0 + 8'h08, seed);
      bus(1'b0, `OFS_PERIOD0 + 8'h08, 32'h0);
      chk(q, {16'h0, seed[15:0]});
      $display("test registers done");
      // divider codes 0 to 4, random prescale, one-shot run of channel 0
      for (int c = 0; c < 5; c++) begin
         seed = xs(seed);
         pv = seed[1:0];
         tk = (int'(pv) + 1) << c;
         bus(1'b1, `OFS_PRESCALE, {30'h0, pv});
         bus(1'b1, `OFS_CLKSEL, 32'(c));
         bus(1'b1, `OFS_PERIOD0, 32'h8);
         bus(1'b1, `OFS_PERIOD0 + 8'h04, 32'h4);
         bus(1'b1, `OFS_IRQ_EN, 32'h1);
         bus(1'b1, `OFS_CTRL, 32'h1);
         wait_irq(1000);
         chk(32'(t >= 7 * tk && t <= 9 * tk + 8), 32'h1);
         chk(32'(hi0 >= 3 * tk && hi0 <= 5 * tk + 4), 32'h1);
         bus(1'b0, `OFS_COUNT0, 32'h0);
         chk(q, 32'h0);
         chk({31'h0, pwm_out[0]}, 32'h0);
         bus(1'b0, `OFS_IRQ_IND, 32'h0);
         chk(q, 32'h1);
         bus(1'b1, `OFS_IRQ_IND, 32'h1);
         @(posedge hclk);
         chk({31'h0, pwm_irq}, 32'h0);
         bus(1'b1, `OFS_CTRL, 32'h0);
      end
      $display("test divider and one-shot done");
      bus(1'b1, `OFS_IRQ_EN, 32'h0);
      bus(1'b1, `OFS_PRESCALE, 32'h0);
      bus(1'b1, `OFS_CLKSEL, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h1);
      watch(40);
      chk({31'h0, pwm_irq}, 32'h0);
      bus(1'b0, `OFS_IRQ_IND, 32'h0);
      chk(q, 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h0);
      // auto-reload; a new period only lands at the next zero
      bus(1'b1, `OFS_CTRL, 32'h3);
      t = 0;
      q = 32'h0;
      while (q < 32'h6 && t < 50) begin
         bus(1'b0, `OFS_COUNT0, 32'h0);
         t++;
      end
      bus(1'b1, `OFS_PERIOD0, 32'd40);
      bus(1'b0, `OFS_COUNT0, 32'h0);
      chk(32'(q <= 32'h8), 32'h1);
      watch(12);
      bus(1'b0, `OFS_COUNT0, 32'h0);
      chk(32'(q > 32'h8 && q <= 32'd40), 32'h1);
      // complementary pair from timer 0
      bus(1'b1, `OFS_DEADTIME, 32'h2);
      bus(1'b1, `OFS_CTRL, 32'h0100_0003);
      watch(300);
      chk({31'h0, overlap}, 32'h0);
      chk(32'(hi0 > 0 && hi1 > 0), 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h0);
      // center-aligned: the counter climbs back up after zero, edge mode only jumps
      bus(1'b1, `OFS_CTRL, 32'h7);
      hi1 = 0;
      for (int i = 0; i < 40; i++) begin
         tk = int'(q[15:0]);
         bus(1'b0, `OFS_COUNT0, 32'h0);
         if (q > 32'(tk) && q <= 32'(tk + 3)) begin
            hi1++;
         end
      end
      chk(32'(hi1 > 0), 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h0);
      bus(1'b1, `OFS_IRQ_IND, 32'hffff);
      $display("test reload and dead zone done");
      // capture on channel 0, rising interrupt only
      bus(1'b1, `OFS_PERIOD0, 32'd100);
      bus(1'b1, `OFS_CTRL, 32'h3);
      bus(1'b1, `OFS_CAPCTL0, 32'h3);
      chk({30'h0, pwm_oe[1:0]}, 32'h2);
      watch(60);
      src <= 8'h01;
      watch(4);
      chk({31'h0, pwm_irq}, 32'h1);
      bus(1'b0, `OFS_IRQ_IND, 32'h0);
      chk(q & 32'hff00, 32'h0100);
      bus(1'b0, `OFS_LATCH0, 32'h0);
      chk(32'(q >= 32'd20 && q <= 32'd60), 32'h1);
      bus(1'b0, `OFS_COUNT0, 32'h0);
      chk(32'(q >= 32'd85 && q <= 32'd100), 32'h1);
      bus(1'b1, `OFS_IRQ_IND, 32'h0100);
      src <= 8'h00;
      watch(4);
      bus(1'b0, `OFS_IRQ_IND, 32'h0);
      chk(q & 32'hff00, 32'h0);
      bus(1'b0, `OFS_LATCH0 + 8'h04, 32'h0);
      chk(32'(q >= 32'd70 && q <= 32'd100), 32'h1);
      $display("test capture done");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
